// >>> logic/station_cfg_pkg.sv
package station_cfg_pkg;
	// Bus geometry
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] SWRAW_OFS  = 8'h08;

	// Control register fields and reset value
	localparam int unsigned CTRL_LINK_EN_BIT = 0;
	localparam logic        CTRL_LINK_EN_RST = 1'b1;

	// Status register field positions
	localparam int unsigned ST_DONE_BIT     = 0;
	localparam int unsigned ST_RATE_BIT     = 1;
	localparam int unsigned ST_FRAME_BIT    = 2;
	localparam int unsigned ST_VALID_BIT    = 3;
	localparam int unsigned ST_RSVD_ON_BIT  = 4;
	localparam int unsigned ST_LINK_BIT     = 5;
	localparam int unsigned ST_ADDR_LSB     = 8;
	localparam int unsigned ST_FLEN_LSB     = 16;

	// Raw switch register field positions
	localparam int unsigned RAW_DIP_LSB = 0;
	localparam int unsigned RAW_ROT_LSB = 4;

	// Configuration switch positions
	localparam int unsigned DIP_RATE_BIT  = 0;
	localparam int unsigned DIP_FRAME_BIT = 1;
	localparam int unsigned DIP_BASE_BIT  = 2;
	localparam int unsigned DIP_RSVD_BIT  = 3;

	// Decoded values
	localparam logic [5:0] FRAME_LEN_SHORT = 6'h11;
	localparam logic [5:0] FRAME_LEN_LONG  = 6'h20;
	localparam logic [7:0] ADDR_BASE_LOW   = 8'h40;
	localparam logic [7:0] ADDR_BASE_HIGH  = 8'h50;
	localparam logic [7:0] ADDR_DEFAULT    = 8'h41;

	// Response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : station_cfg_pkg

// >>> logic/switch_config_latch.sv
`timescale 1ns/10ps
module switch_config_latch (
	// Clock and reset
	input  wire logic                  ref_clk_i,
	input  wire logic                  rst_n_i,
	// Switch levels
	input  wire logic [3:0]            dip_config_switch_i,
	input  wire logic [3:0]            rotary_address_switch_i,
	// Decoded configuration
	output logic                       cfg_done_o,
	output logic                       rate_10m_o,
	output logic [5:0]                 frame_len_o,
	output logic [7:0]                 station_addr_o,
	output logic                       addr_valid_o,
	output logic [3:0]                 raw_dip_o,
	output logic [3:0]                 raw_rot_o
);
	import station_cfg_pkg::*;

	// Address base picked by the third position
	function automatic logic [7:0] addr_of(input logic [3:0] dip, input logic [3:0] rot);
		addr_of = (dip[DIP_BASE_BIT] ? ADDR_BASE_HIGH : ADDR_BASE_LOW) + {4'h0, rot};
	endfunction : addr_of

	logic       done_reg,  done_next;   // Capture has happened
	logic       rate_reg,  rate_next;   // 10 Mbps selected
	logic [5:0] flen_reg,  flen_next;   // Frame length in bytes
	logic [7:0] addr_reg,  addr_next;   // Station address
	logic       valid_reg, valid_next;  // Address usable
	logic [3:0] dip_reg,   dip_next;    // Captured DIP levels
	logic [3:0] rot_reg,   rot_next;    // Captured rotary digit

	// Capture once; reset is the only way to take new settings
	always_comb begin
		done_next  = done_reg;
		rate_next  = rate_reg;
		flen_next  = flen_reg;
		addr_next  = addr_reg;
		valid_next = valid_reg;
		dip_next   = dip_reg;
		rot_next   = rot_reg;
		if (!done_reg) begin
			done_next  = 1'b1;
			dip_next   = dip_config_switch_i;
			rot_next   = rotary_address_switch_i;
			rate_next  = dip_config_switch_i[DIP_RATE_BIT];
			flen_next  = (dip_config_switch_i[DIP_RATE_BIT] &&
				dip_config_switch_i[DIP_FRAME_BIT]) ? FRAME_LEN_LONG : FRAME_LEN_SHORT;
			addr_next  = addr_of(dip_config_switch_i, rotary_address_switch_i);
			valid_next = dip_config_switch_i[DIP_BASE_BIT] || (rotary_address_switch_i != 4'h0);
		end
	end

	// Constants only under reset; switches are read after release
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			done_reg  <= 1'b0;
			rate_reg  <= 1'b0;
			flen_reg  <= FRAME_LEN_SHORT;
			addr_reg  <= 8'h00;
			valid_reg <= 1'b0;
			dip_reg   <= 4'h0;
			rot_reg   <= 4'h0;
		end else begin
			done_reg  <= done_next;
			rate_reg  <= rate_next;
			flen_reg  <= flen_next;
			addr_reg  <= addr_next;
			valid_reg <= valid_next;
			dip_reg   <= dip_next;
			rot_reg   <= rot_next;
		end
	end

	assign cfg_done_o     = done_reg;
	assign rate_10m_o     = rate_reg;
	assign frame_len_o    = flen_reg;
	assign station_addr_o = addr_reg;
	assign addr_valid_o   = valid_reg;
	assign raw_dip_o      = dip_reg;
	assign raw_rot_o      = rot_reg;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_capture;
		!done_reg ##1 done_reg;
	endsequence

	property p_rate_sel;
		s_capture |-> rate_reg == $past(dip_config_switch_i[DIP_RATE_BIT]);
	endproperty
	a_rate_sel: assert property (p_rate_sel) else $error("rate not from first position");

	property p_frame_long;
		done_reg && dip_reg[DIP_RATE_BIT] |-> flen_reg ==
			(dip_reg[DIP_FRAME_BIT] ? FRAME_LEN_LONG : FRAME_LEN_SHORT);
	endproperty
	a_frame_long: assert property (p_frame_long) else $error("frame length wrong");

	property p_addr_form;
		s_capture |-> addr_reg == ($past(dip_config_switch_i[DIP_BASE_BIT]) ? 8'h50 : 8'h40)
			+ {4'h0, $past(rotary_address_switch_i)};
	endproperty
	a_addr_form: assert property (p_addr_form) else $error("station address wrong");

	property p_addr_valid;
		done_reg |-> valid_reg == !(!dip_reg[DIP_BASE_BIT] && rot_reg == 4'h0);
	endproperty
	a_addr_valid: assert property (p_addr_valid) else $error("address validity wrong");

	property p_legacy_short;
		done_reg && !rate_reg |-> flen_reg == 6'h11;
	endproperty
	a_legacy_short: assert property (p_legacy_short) else $error("legacy frame not 17");

	property p_default_addr;
		done_reg && !dip_reg[DIP_BASE_BIT] && rot_reg == 4'h1 |-> addr_reg == 8'h41 && valid_reg;
	endproperty
	a_default_addr: assert property (p_default_addr) else $error("default address not 41");

	property p_hold;
		done_reg |=> $stable(addr_reg) && $stable(rate_reg) && $stable(flen_reg) && done_reg;
	endproperty
	a_hold: assert property (p_hold) else $error("settings changed while powered");

	property p_sample_once;
		!done_reg |=> done_reg;
	endproperty
	a_sample_once: assert property (p_sample_once) else $error("no capture after reset");
endmodule : switch_config_latch

// >>> logic/fieldbus_station_switch_config.sv
`timescale 1ns/10ps
// Contract
// - First position picks 4 or 10 Mbps.
// - Second position picks 17 or 32 bytes.
// - Address is 40H or 50H plus digit.
// - Base 40H with digit zero is disabled.
// - Legacy rate forces 17-byte frames.
// - Factory default address is 41H.
// - Changes apply only after power cycle.
module fieldbus_station_switch_config (
	// Clock and reset
	input  wire logic                                  ref_clk_i,
	input  wire logic                                  rst_n_i,
	// Switch levels
	input  wire logic [3:0]                            dip_config_switch_i,
	input  wire logic [3:0]                            rotary_address_switch_i,
	// Decoded link settings
	output logic                                       rate_10m_o,
	output logic [5:0]                                 frame_len_o,
	output logic [7:0]                                 station_addr_o,
	output logic                                       addr_valid_o,
	output logic                                       link_enable_o,
	// AXI4-Lite write address and data
	input  wire logic [station_cfg_pkg::ADDR_W-1:0]    s_axi_awaddr_i,
	input  wire logic                                  s_axi_awvalid_i,
	output logic                                       s_axi_awready_o,
	input  wire logic [station_cfg_pkg::DATA_W-1:0]    s_axi_wdata_i,
	input  wire logic [3:0]                            s_axi_wstrb_i,
	input  wire logic                                  s_axi_wvalid_i,
	output logic                                       s_axi_wready_o,
	// AXI4-Lite write response
	output logic [1:0]                                 s_axi_bresp_o,
	output logic                                       s_axi_bvalid_o,
	input  wire logic                                  s_axi_bready_i,
	// AXI4-Lite read
	input  wire logic [station_cfg_pkg::ADDR_W-1:0]    s_axi_araddr_i,
	input  wire logic                                  s_axi_arvalid_i,
	output logic                                       s_axi_arready_o,
	output logic [station_cfg_pkg::DATA_W-1:0]         s_axi_rdata_o,
	output logic [1:0]                                 s_axi_rresp_o,
	output logic                                       s_axi_rvalid_o,
	input  wire logic                                  s_axi_rready_i
);
	import station_cfg_pkg::*;

	typedef enum logic [1:0] {
		SEL_CTRL   = 2'b00,
		SEL_STATUS = 2'b01,
		SEL_SWRAW  = 2'b10,
		SEL_NONE   = 2'b11
	} reg_sel_e;

	typedef enum logic {
		WR_ACCEPT = 1'b0,
		WR_RESP   = 1'b1
	} wr_state_e;

	typedef enum logic {
		RD_ACCEPT = 1'b0,
		RD_RESP   = 1'b1
	} rd_state_e;

	// Word decode shared by both channels
	function automatic reg_sel_e decode(input logic [ADDR_W-1:0] a);
		unique case ({a[ADDR_W-1:2], 2'b00})
			CTRL_OFS:   decode = SEL_CTRL;
			STATUS_OFS: decode = SEL_STATUS;
			SWRAW_OFS:  decode = SEL_SWRAW;
			default:    decode = SEL_NONE;
		endcase
	endfunction : decode

	// Latched switch configuration
	logic       cfg_done;
	logic       cfg_rate;
	logic [5:0] cfg_flen;
	logic [7:0] cfg_addr;
	logic       cfg_valid;
	logic [3:0] cfg_dip;
	logic [3:0] cfg_rot;

	// Capture happens once, one edge after reset release
	switch_config_latch u_latch (
		.ref_clk_i               (ref_clk_i),
		.rst_n_i                 (rst_n_i),
		.dip_config_switch_i     (dip_config_switch_i),
		.rotary_address_switch_i (rotary_address_switch_i),
		.cfg_done_o              (cfg_done),
		.rate_10m_o              (cfg_rate),
		.frame_len_o             (cfg_flen),
		.station_addr_o          (cfg_addr),
		.addr_valid_o            (cfg_valid),
		.raw_dip_o               (cfg_dip),
		.raw_rot_o               (cfg_rot)
	);

	// Write side state
	wr_state_e         wr_state_reg, wr_state_next;
	logic              aw_held_reg,  aw_held_next;   // Address taken, waiting for data
	logic              w_held_reg,   w_held_next;    // Data taken, waiting for address
	logic [ADDR_W-1:0] awaddr_reg,   awaddr_next;
	logic [DATA_W-1:0] wdata_reg,    wdata_next;
	logic [3:0]        wstrb_reg,    wstrb_next;
	logic              awready_reg,  awready_next;
	logic              wready_reg,   wready_next;
	logic              bvalid_reg,   bvalid_next;
	logic [1:0]        bresp_reg,    bresp_next;
	logic              link_en_reg,  link_en_next;   // Software link gate

	// Read side state
	rd_state_e         rd_state_reg, rd_state_next;
	logic              arready_reg,  arready_next;
	logic              rvalid_reg,   rvalid_next;
	logic [1:0]        rresp_reg,    rresp_next;
	logic [DATA_W-1:0] rdata_reg,    rdata_next;

	// Output stage
	logic              rate_reg,  rate_next;
	logic [5:0]        flen_reg,  flen_next;
	logic [7:0]        addr_reg,  addr_next;
	logic              valid_reg, valid_next;
	logic              link_reg,  link_next;

	logic [DATA_W-1:0] status_word;  // Live status view
	logic [DATA_W-1:0] raw_word;     // Captured switch view

	always_comb begin
		status_word = '0;
		status_word[ST_DONE_BIT]    = cfg_done;
		status_word[ST_RATE_BIT]    = cfg_rate;
		status_word[ST_FRAME_BIT]   = (cfg_flen == FRAME_LEN_LONG);
		status_word[ST_VALID_BIT]   = cfg_valid;
		status_word[ST_RSVD_ON_BIT] = cfg_dip[DIP_RSVD_BIT];
		status_word[ST_LINK_BIT]    = link_reg;
		status_word[ST_ADDR_LSB +: 8] = cfg_addr;
		status_word[ST_FLEN_LSB +: 6] = cfg_flen;
		raw_word = '0;
		raw_word[RAW_DIP_LSB +: 4] = cfg_dip;
		raw_word[RAW_ROT_LSB +: 4] = cfg_rot;
	end

	// Write channel: address and data in either order
	always_comb begin
		wr_state_next = wr_state_reg;
		aw_held_next  = aw_held_reg;
		w_held_next   = w_held_reg;
		awaddr_next   = awaddr_reg;
		wdata_next    = wdata_reg;
		wstrb_next    = wstrb_reg;
		bvalid_next   = bvalid_reg;
		bresp_next    = bresp_reg;
		link_en_next  = link_en_reg;
		if (s_axi_awvalid_i && awready_reg) begin
			aw_held_next = 1'b1;
			awaddr_next  = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && wready_reg) begin
			w_held_next = 1'b1;
			wdata_next  = s_axi_wdata_i;
			wstrb_next  = s_axi_wstrb_i;
		end
		unique case (wr_state_reg)
			WR_ACCEPT: begin
				// Both halves present: commit and answer
				if (aw_held_next && w_held_next) begin
					aw_held_next  = 1'b0;
					w_held_next   = 1'b0;
					bvalid_next   = 1'b1;
					wr_state_next = WR_RESP;
					bresp_next    = RESP_OKAY;
					unique case (decode(awaddr_next))
						SEL_CTRL: begin
							if (wstrb_next[0]) begin
								link_en_next = wdata_next[CTRL_LINK_EN_BIT];
							end
						end
						// Status views ignore writes
						SEL_STATUS, SEL_SWRAW: bresp_next = RESP_OKAY;
						SEL_NONE:              bresp_next = RESP_SLVERR;
					endcase
				end
			end
			WR_RESP: begin
				if (s_axi_bready_i) begin
					bvalid_next   = 1'b0;
					wr_state_next = WR_ACCEPT;
				end
			end
		endcase
		// Ready only while a slot is free, so nothing is taken twice
		awready_next = (wr_state_next == WR_ACCEPT) && !aw_held_next;
		wready_next  = (wr_state_next == WR_ACCEPT) && !w_held_next;
	end

	// Read channel: one outstanding read
	always_comb begin
		rd_state_next = rd_state_reg;
		rvalid_next   = rvalid_reg;
		rresp_next    = rresp_reg;
		rdata_next    = rdata_reg;
		unique case (rd_state_reg)
			RD_ACCEPT: begin
				if (s_axi_arvalid_i && arready_reg) begin
					rvalid_next   = 1'b1;
					rd_state_next = RD_RESP;
					rresp_next    = RESP_OKAY;
					unique case (decode(s_axi_araddr_i))
						SEL_CTRL:   rdata_next = {{(DATA_W-1){1'b0}}, link_en_reg};
						SEL_STATUS: rdata_next = status_word;
						SEL_SWRAW:  rdata_next = raw_word;
						SEL_NONE: begin
							rdata_next = '0;
							rresp_next = RESP_SLVERR;
						end
					endcase
				end
			end
			RD_RESP: begin
				if (s_axi_rready_i) begin
					rvalid_next   = 1'b0;
					rd_state_next = RD_ACCEPT;
				end
			end
		endcase
		arready_next = (rd_state_next == RD_ACCEPT);
	end

	// Outputs mirror the latch, gated until the capture is done
	always_comb begin
		rate_next  = cfg_done && cfg_rate;
		flen_next  = cfg_done ? cfg_flen : FRAME_LEN_SHORT;
		addr_next  = cfg_done ? cfg_addr : 8'h00;
		valid_next = cfg_done && cfg_valid;
		link_next  = cfg_done && cfg_valid && link_en_reg;
	end

	// Single register stage for every group
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_state_reg <= WR_ACCEPT;
			aw_held_reg  <= 1'b0;
			w_held_reg   <= 1'b0;
			awaddr_reg   <= '0;
			wdata_reg    <= '0;
			wstrb_reg    <= 4'h0;
			awready_reg  <= 1'b0;
			wready_reg   <= 1'b0;
			bvalid_reg   <= 1'b0;
			bresp_reg    <= RESP_OKAY;
			link_en_reg  <= CTRL_LINK_EN_RST;
			rd_state_reg <= RD_ACCEPT;
			arready_reg  <= 1'b0;
			rvalid_reg   <= 1'b0;
			rresp_reg    <= RESP_OKAY;
			rdata_reg    <= '0;
			rate_reg     <= 1'b0;
			flen_reg     <= FRAME_LEN_SHORT;
			addr_reg     <= 8'h00;
			valid_reg    <= 1'b0;
			link_reg     <= 1'b0;
		end else begin
			wr_state_reg <= wr_state_next;
			aw_held_reg  <= aw_held_next;
			w_held_reg   <= w_held_next;
			awaddr_reg   <= awaddr_next;
			wdata_reg    <= wdata_next;
			wstrb_reg    <= wstrb_next;
			awready_reg  <= awready_next;
			wready_reg   <= wready_next;
			bvalid_reg   <= bvalid_next;
			bresp_reg    <= bresp_next;
			link_en_reg  <= link_en_next;
			rd_state_reg <= rd_state_next;
			arready_reg  <= arready_next;
			rvalid_reg   <= rvalid_next;
			rresp_reg    <= rresp_next;
			rdata_reg    <= rdata_next;
			rate_reg     <= rate_next;
			flen_reg     <= flen_next;
			addr_reg     <= addr_next;
			valid_reg    <= valid_next;
			link_reg     <= link_next;
		end
	end

	assign s_axi_awready_o = awready_reg;
	assign s_axi_wready_o  = wready_reg;
	assign s_axi_bvalid_o  = bvalid_reg;
	assign s_axi_bresp_o   = bresp_reg;
	assign s_axi_arready_o = arready_reg;
	assign s_axi_rvalid_o  = rvalid_reg;
	assign s_axi_rresp_o   = rresp_reg;
	assign s_axi_rdata_o   = rdata_reg;
	assign rate_10m_o      = rate_reg;
	assign frame_len_o     = flen_reg;
	assign station_addr_o  = addr_reg;
	assign addr_valid_o    = valid_reg;
	assign link_enable_o   = link_reg;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_out_rate;
		cfg_done |=> rate_10m_o == $past(cfg_rate) && frame_len_o == $past(cfg_flen);
	endproperty
	a_out_rate: assert property (p_out_rate) else $error("line settings not mirrored");

	property p_out_legacy;
		cfg_done && !rate_10m_o |-> frame_len_o == 6'h11;
	endproperty
	a_out_legacy: assert property (p_out_legacy) else $error("legacy output frame not 17");

	property p_out_link;
		link_enable_o |-> addr_valid_o && station_addr_o != 8'h40;
	endproperty
	a_out_link: assert property (p_out_link) else $error("link up on disabled address");

	property p_out_stable;
		cfg_done ##1 cfg_done |=> $stable(station_addr_o) && $stable(rate_10m_o);
	endproperty
	a_out_stable: assert property (p_out_stable) else $error("address moved after capture");

	property p_out_ready;
		$rose(cfg_done) |-> ##[1:2] (addr_valid_o == cfg_valid);
	endproperty
	a_out_ready: assert property (p_out_ready) else $error("outputs late after capture");
endmodule : fieldbus_station_switch_config

// >>> verif/station_setup_model.sv
`timescale 1ns/10ps
// Installer and network master side: sets the station switches before power-up
module station_setup_model (
	// Clock
	input  wire logic       ref_clk_i,
	// Wanted settings from the bench
	input  wire logic [3:0] want_dip_i,
	input  wire logic [3:0] want_rot_i,
	input  wire logic       misuse_i,
	// Switch levels seen by the drive
	output logic      [3:0] dip_config_switch_o,
	output logic      [3:0] rotary_address_switch_o
);
	// Switch levels move only just after an edge, like any other stimulus
	always_ff @(posedge ref_clk_i) begin
		rotary_address_switch_o <= want_rot_i;
		if (misuse_i) begin
			// Deliberately careless setup, only when the bench asks for it
			dip_config_switch_o <= want_dip_i;
		end else begin
			dip_config_switch_o <= {1'b0, want_dip_i[2], want_dip_i[1] & want_dip_i[0],
				want_dip_i[0]};
		end
	end
endmodule : station_setup_model

// >>> verif/test_fieldbus_station_switch_config.sv
`timescale 1ns/10ps
module test_fieldbus_station_switch_config;
	import station_cfg_pkg::*;
	// Clock, reset and wanted switch settings
	logic        ref_clk_i = 1'b0;
	logic        rst_n_i   = 1'b0;
	logic [3:0]  want_dip  = 4'h0;
	logic [3:0]  want_rot  = 4'h0;
	logic        misuse    = 1'b0;
	wire  [3:0]  dip;
	wire  [3:0]  rot;
	// Register bus, master side
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata  = 32'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	wire         awready, wready, bvalid, arready, rvalid;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	// Decoded settings
	wire         rate, valid, link;
	wire  [5:0]  flen;
	wire  [7:0]  addr;
	// Scoreboard
	int          bad_count = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	logic [31:0] rd, st;
	logic [1:0]  rs;

	station_setup_model i_setup (.ref_clk_i(ref_clk_i), .want_dip_i(want_dip),
		.want_rot_i(want_rot), .misuse_i(misuse), .dip_config_switch_o(dip),
		.rotary_address_switch_o(rot));

	fieldbus_station_switch_config i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.dip_config_switch_i(dip), .rotary_address_switch_i(rot),
		.rate_10m_o(rate), .frame_len_o(flen), .station_addr_o(addr),
		.addr_valid_o(valid), .link_enable_o(link),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));

	// 100 MHz clock
	initial begin
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	// Hang guard, far above the roughly 1250 cycles the tests need
	always @(posedge ref_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			bad_count++;
			conclude();
		end
	end

	task conclude();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude

	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One write; each channel held until its own ready, bready until bvalid
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge ref_clk_i);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		check({30'h0, bresp}, {30'h0, er});
	endtask : wr

	// One read; data and response taken at the rvalid edge
	task rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk_i);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
	endtask : rd_reg

	// Status word expected from the captured switches
	function logic [31:0] exp_status(input logic [3:0] d, input logic [3:0] r, input logic en);
		logic [7:0] a;
		logic       v;
		logic [5:0] f;
		a = (d[2] ? ADDR_BASE_HIGH : ADDR_BASE_LOW) + {4'h0, r};
		v = d[2] | (r != 4'h0);
		f = (d[0] & d[1]) ? FRAME_LEN_LONG : FRAME_LEN_SHORT;
		return {10'h0, f, a, 2'b00, v & en, d[3], v, d[0] & d[1], d[0], 1'b1};
	endfunction : exp_status

	// Power cycle with new switches, then disturb them while running
	task power_cycle(input logic [3:0] d, input logic [3:0] r, input logic m);
		logic [3:0] cd;
		logic [3:0] cr;
		@(posedge ref_clk_i);
		rst_n_i  <= 1'b0;
		want_dip <= d;
		want_rot <= r;
		misuse   <= m;
		repeat (8) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		cd = dip;
		cr = rot;
		repeat (3) @(posedge ref_clk_i);
		st = exp_status(cd, cr, 1'b1);
		#1;
		check({15'h0, link, rate, valid, flen, addr},
			{15'h0, st[5], st[1], st[3], st[21:16], st[15:8]});
		rd_reg(SWRAW_OFS, rd, rs);
		check(rd, {24'h0, cr, cd});
		check({30'h0, rs}, {30'h0, RESP_OKAY});
		rd_reg(STATUS_OFS, rd, rs);
		check(rd, st);
		// Switches turned while powered must change nothing
		want_dip <= ~d;
		want_rot <= ~r;
		misuse   <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		rd_reg(STATUS_OFS, rd, rs);
		check(rd, st);
		#1;
		check({24'h0, addr}, {24'h0, st[15:8]});
	endtask : power_cycle

	initial begin
		void'($urandom(79089));
		// Factory setting of both switches
		power_cycle(4'h3, 4'h1, 1'b0);
		check({24'h0, addr}, {24'h0, ADDR_DEFAULT});
		rd_reg(CTRL_OFS, rd, rs);
		check(rd, {31'h0, CTRL_LINK_EN_RST});
		check({30'h0, rs}, {30'h0, RESP_OKAY});
		$display("test factory_default done");
		// Link enable off and on, read-only and unmapped places
		wr(CTRL_OFS, 32'h0, RESP_OKAY);
		rd_reg(STATUS_OFS, rd, rs);
		check(rd, exp_status(4'h3, 4'h1, 1'b0));
		check({31'h0, link}, 32'h0);
		wr(STATUS_OFS, 32'hffff_ffff, RESP_OKAY);
		wr(8'h0c, 32'h1, RESP_SLVERR);
		rd_reg(8'h0c, rd, rs);
		check(rd, 32'h0);
		check({30'h0, rs}, {30'h0, RESP_SLVERR});
		wr(CTRL_OFS, 32'h1, RESP_OKAY);
		rd_reg(STATUS_OFS, rd, rs);
		check(rd, exp_status(4'h3, 4'h1, 1'b1));
		$display("test registers done");
		// Every switch combination, digits 0 and F at each base, then random digits
		for (int i = 0; i < 32; i++) begin
			power_cycle(4'(i), i[4] ? 4'($urandom) : (i[0] ? 4'hf : 4'h0), 1'b1);
		end
		$display("test all_settings done");
		// Random settings through a careful setup
		repeat (16) power_cycle(4'($urandom), 4'($urandom), 1'b0);
		$display("test random_settings done");
		conclude();
	end
endmodule : test_fieldbus_station_switch_config
